// ===== include/fsl_cfg.svh
// fsl_cfg.svh: timing counts and pattern slot positions for the status indicator encoder.
// assumes the core clock runs at 20 MHz; included by bare name from every design file.
`ifndef FSL_CFG_SVH
`define FSL_CFG_SVH

// core clock rate in hertz
`define FSL_CLK_HZ 20000000
// length of one pattern slot in milliseconds
`define FSL_TICK_MS 200
// cycles in one slot, derived from the rate and the slot length
`define FSL_TICK_CYCLES ((`FSL_CLK_HZ / 1000) * `FSL_TICK_MS)
// prescaler width, wide enough for the default slot count
`define FSL_PRESCALE_W 22
// slot counter width: a pattern frame has eight slots
`define FSL_SLOT_W 3
// slots in which the single and double flash patterns are lit
`define FSL_SLOT_FLASH1 3'h0
`define FSL_SLOT_FLASH2 3'h2
// indicator event timing, in slots
`define FSL_SEQ_W 3
`define FSL_GOOD_DARK_TICKS 3'h2
`define FSL_NOREAD_DARK_TICKS 3'h2
`define FSL_NOREAD_RED_TICKS 3'h2

`endif

// ===== include/fsl_pkg.sv
// fsl_pkg: types shared by the status indicator encoder and its submodules.
// assumes nothing of its surroundings; holds types only.
package fsl_pkg;

   // fieldbus slave states in start-up order
   typedef enum logic [1:0] {FSL_ST_INIT, FSL_ST_PREOP, FSL_ST_SAFEOP, FSL_ST_OP} fsl_slave_state_t;

   // power indicator event sequencer states
   typedef enum logic [1:0] {FSL_SEQ_IDLE, FSL_SEQ_DARK, FSL_SEQ_RED} fsl_seq_state_t;

   // two-colour indicator drive; both lit shows orange
   typedef struct packed {
      logic green;
      logic red;
   } fsl_led_t;

   // device core condition
   typedef struct packed {
      logic init_done;
      logic service_mode;
      logic warning;
      logic error;
   } fsl_dev_status_t;

   // watchdog expiry levels
   typedef struct packed {
      logic pd_wdg;
      logic bus_wdg;
      logic sm_wdg;
   } fsl_wdg_t;

   // flash pattern levels from the pattern generator
   typedef struct packed {
      logic blink;
      logic single;
      logic dbl;
   } fsl_pattern_t;

   // state change request from the master
   typedef struct packed {
      logic valid;
      fsl_slave_state_t target;
   } fsl_al_req_t;

endpackage : fsl_pkg

// ===== design/fsl_pattern_gen.sv
// fsl_pattern_gen: prescaled slot tick and the steady, single and double flash levels.
// assumes one core clock; the slot length is a parameter so simulation can shorten it.
`timescale 1ns/10ps
`default_nettype none
`include "fsl_cfg.svh"

module fsl_pattern_gen
   import fsl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `FSL_TICK_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   output logic o_tick,
   output fsl_pattern_t o_pattern
);

   logic [`FSL_PRESCALE_W-1:0] cnt_ff;
   logic [`FSL_SLOT_W-1:0] slot_ff;
   logic tick_ff;
   fsl_pattern_t pat_ff;
   logic wrap;

   assign wrap = (cnt_ff == `FSL_PRESCALE_W'(TICK_CYCLES - 1));

   // prescaler: one tick pulse per slot length
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
         tick_ff <= wrap;
      end
   end

   // slot counter walks an eight-slot frame
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         slot_ff <= '0;
      end else if (tick_ff) begin
         slot_ff <= slot_ff + 1'b1;
      end
   end

   // patterns are registered so the indicators see glitch-free levels
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pat_ff <= '0;
      end else begin
         pat_ff.blink <= ~slot_ff[0];
         pat_ff.single <= (slot_ff == `FSL_SLOT_FLASH1);
         pat_ff.dbl <= (slot_ff == `FSL_SLOT_FLASH1) || (slot_ff == `FSL_SLOT_FLASH2);
      end
   end

   assign o_tick = tick_ff;
   assign o_pattern = pat_ff;

   chk_tick_period: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      tick_ff |-> ($past(cnt_ff) == `FSL_PRESCALE_W'(TICK_CYCLES - 1)))
      else $error("slot tick not at end of prescale count");

endmodule : fsl_pattern_gen
`default_nettype wire

// ===== design/fsl_read_seq.sv
// fsl_read_seq: power indicator sequence after a read: dark then green, or dark, red, green.
// assumes one-cycle read result pulses and the slot tick from the pattern generator.
`timescale 1ns/10ps
`default_nettype none
`include "fsl_cfg.svh"

module fsl_read_seq
   import fsl_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_tick,
   input wire logic i_good_read,
   input wire logic i_no_read,
   output logic o_busy,
   output fsl_led_t o_color
);

   fsl_seq_state_t state_ff;
   fsl_seq_state_t nxt_state;
   logic [`FSL_SEQ_W-1:0] cnt_ff;
   logic [`FSL_SEQ_W-1:0] nxt_cnt;
   logic noread_ff;
   logic nxt_noread;
   fsl_led_t color_ff;
   logic last;

   assign last = i_tick && (cnt_ff == `FSL_SEQ_W'(1));

   // next state: a new result restarts the sequence; a miss wins over a hit in one cycle
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_noread = noread_ff;
      if (i_no_read) begin
         nxt_state = FSL_SEQ_DARK;
         nxt_cnt = `FSL_NOREAD_DARK_TICKS;
         nxt_noread = 1'b1;
      end else if (i_good_read) begin
         nxt_state = FSL_SEQ_DARK;
         nxt_cnt = `FSL_GOOD_DARK_TICKS;
         nxt_noread = 1'b0;
      end else begin
         case (state_ff)
            FSL_SEQ_IDLE: begin
               nxt_cnt = '0;
            end
            FSL_SEQ_DARK: begin
               if (last && noread_ff) begin
                  nxt_state = FSL_SEQ_RED;
                  nxt_cnt = `FSL_NOREAD_RED_TICKS;
               end else if (last) begin
                  nxt_state = FSL_SEQ_IDLE;
               end else if (i_tick) begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            FSL_SEQ_RED: begin
               if (last) begin
                  nxt_state = FSL_SEQ_IDLE;
               end else if (i_tick) begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            default: begin
               nxt_state = FSL_SEQ_IDLE;
            end
         endcase
      end
   end

   // sequence state; the count of two slots keeps the shortest phase above one slot
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_ff <= FSL_SEQ_IDLE;
         cnt_ff <= '0;
         noread_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         noread_ff <= nxt_noread;
      end
   end

   // colour registered from the next state so it lines up with the state
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         color_ff.green <= 1'b1; // idle shows green, so a ready device is green from the first edge
         color_ff.red <= 1'b0;
      end else begin
         color_ff.green <= (nxt_state == FSL_SEQ_IDLE);
         color_ff.red <= (nxt_state == FSL_SEQ_RED);
      end
   end

   assign o_busy = (state_ff != FSL_SEQ_IDLE);
   assign o_color = color_ff;

   chk_good_dark: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_good_read && !i_no_read) |=> (o_busy && !o_color.green && !o_color.red))
      else $error("good read did not blank the indicator");

   chk_noread_red: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (state_ff == FSL_SEQ_DARK && noread_ff && last && !i_good_read && !i_no_read)
      |=> (o_color.red && !o_color.green))
      else $error("missed read did not turn red after dark");

   chk_back_green: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (state_ff == FSL_SEQ_RED && last && !i_good_read && !i_no_read)
      |=> (o_color.green && !o_color.red && !o_busy))
      else $error("indicator did not return to green");

endmodule : fsl_read_seq
`default_nettype wire

// ===== design/fsl_status_led.sv
// fsl_status_led: maps device condition and fieldbus slave state onto the power and network indicators.
// assumes all inputs come from logic on the core clock; the master's requests arrive as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "fsl_cfg.svh"

module fsl_status_led
   import fsl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `FSL_TICK_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire fsl_dev_status_t i_dev_status,
   input wire logic i_good_read,
   input wire logic i_no_read,
   input wire logic i_comm_active,
   input wire logic i_master_link,
   input wire fsl_al_req_t i_al_req,
   input wire logic i_cfg_invalid,
   input wire logic i_local_fault,
   input wire fsl_wdg_t i_wdg,
   output fsl_led_t o_power_status_indicator,
   output fsl_led_t o_network_status_indicator,
   output fsl_slave_state_t o_slave_state,
   output logic o_al_refused
);

   logic tick;
   fsl_pattern_t pat;
   logic seq_busy;
   fsl_led_t seq_color;
   fsl_slave_state_t state_ff;
   fsl_slave_state_t nxt_state;
   logic refused_ff;
   logic nxt_refused;
   logic req_legal;
   logic wdg_any;
   logic net_up;
   fsl_led_t pwr_ff;
   fsl_led_t nxt_pwr;
   fsl_led_t net_ff;
   fsl_led_t nxt_net;

   // slot tick and flash levels
   // one shared pattern source keeps both indicators flashing in step
   fsl_pattern_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_pattern (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .o_tick(tick),
      .o_pattern(pat)
   );

   // read result sequence for the power indicator
   fsl_read_seq u_read_seq (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_tick(tick),
      .i_good_read(i_good_read),
      .i_no_read(i_no_read),
      .o_busy(seq_busy),
      .o_color(seq_color)
   );

   // a request is legal one step forward, a step back to any lower state, or a repeat;
   // an invalid configuration blocks the step up from pre-operational to safe-operational
   // taking back-steps lets the master recover from a fault without a device reset
   always_comb begin
      req_legal = 1'b0;
      if (i_al_req.target == state_ff) begin
         req_legal = 1'b1;
      end else if (i_al_req.target < state_ff) begin
         req_legal = 1'b1;
      end else if (i_al_req.target == fsl_slave_state_t'(state_ff + 2'h1)) begin
         req_legal = !(state_ff == FSL_ST_PREOP && i_cfg_invalid);
      end
   end

   // slave state: drops to INIT when communication stops, otherwise only on master command
   // a lost master link alone leaves the state as it is; only the indicator shows the bus error
   always_comb begin
      nxt_state = state_ff;
      nxt_refused = 1'b0;
      if (!i_comm_active) begin
         nxt_state = FSL_ST_INIT;
      end else if (i_al_req.valid && req_legal) begin
         nxt_state = i_al_req.target;
      end else if (i_al_req.valid) begin
         nxt_refused = 1'b1;
      end
   end

   // slave state register and refusal pulse
   // the refusal pulse lets the master see a refused step without polling the state
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_ff <= FSL_ST_INIT;
         refused_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         refused_ff <= nxt_refused;
      end
   end

   // power indicator priority: error, warning, service, initialising, read sequence
   // read results under a higher priority still run the sequencer but stay hidden,
   // so the user sees the fault rather than a flicker from each read
   always_comb begin
      nxt_pwr = '0;
      if (i_dev_status.error) begin
         nxt_pwr.red = 1'b1;
      end else if (i_dev_status.warning) begin
         nxt_pwr.red = pat.blink;
      end else if (i_dev_status.service_mode) begin
         nxt_pwr.green = 1'b1;
         nxt_pwr.red = 1'b1;
      end else if (!i_dev_status.init_done) begin
         nxt_pwr.green = pat.blink;
      end else begin
         nxt_pwr = seq_color;
      end
   end

   // net_up is the case free of bus, watchdog and local faults, in which the slave state and the configuration pick the pattern
   assign wdg_any = i_wdg.pd_wdg || i_wdg.bus_wdg || i_wdg.sm_wdg;
   assign net_up = i_comm_active && i_master_link && !wdg_any && !i_local_fault;

   // network indicator priority: inactive, bus error, watchdog, local fault, configuration, state
   // the order follows how far a fault reaches: no bus first, then lost process data
   always_comb begin
      nxt_net = '0;
      if (!i_comm_active) begin
         nxt_net = '0;
      end else if (!i_master_link) begin
         nxt_net.red = 1'b1;
      end else if (wdg_any) begin
         nxt_net.red = pat.dbl;
      end else if (i_local_fault) begin
         nxt_net.red = pat.single;
      end else if (state_ff == FSL_ST_PREOP && i_cfg_invalid) begin
         nxt_net.red = pat.blink;
      end else begin
         case (state_ff)
            FSL_ST_INIT: begin
               nxt_net = '0;
            end
            FSL_ST_PREOP: begin
               nxt_net.green = pat.blink;
            end
            FSL_ST_SAFEOP: begin
               nxt_net.green = pat.single;
            end
            FSL_ST_OP: begin
               nxt_net.green = 1'b1;
            end
            default: begin
               nxt_net = '0;
            end
         endcase
      end
   end

   // indicator registers; reset holds both dark, as for an unpowered device
   // registering costs one cycle of latency but keeps comparator glitches off the pins
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pwr_ff <= '0;
         net_ff <= '0;
      end else begin
         pwr_ff <= nxt_pwr;
         net_ff <= nxt_net;
      end
   end

   // outputs come straight from flip-flops; nothing combinational reaches the pins
   assign o_power_status_indicator = pwr_ff;
   assign o_network_status_indicator = net_ff;
   assign o_slave_state = state_ff;
   assign o_al_refused = refused_ff;

   // checks of the indicator mapping and the slave state walk
   // each mapping check names the fault-free case, since a higher fault masks the state
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   chk_net_dark_idle: assert property (
      !i_comm_active |=> (!net_ff.green && !net_ff.red && state_ff == FSL_ST_INIT))
      else $error("network indicator lit while communication inactive");

   chk_state_order: assert property (
      (state_ff != $past(state_ff)) |->
         (state_ff == FSL_ST_INIT || state_ff < $past(state_ff)
          || state_ff == fsl_slave_state_t'($past(state_ff) + 2'h1)))
      else $error("slave state skipped a step");

   chk_skip_refused: assert property (
      (i_comm_active && i_al_req.valid && i_al_req.target > state_ff
       && i_al_req.target != fsl_slave_state_t'(state_ff + 2'h1))
      |=> (o_al_refused && state_ff == $past(state_ff)))
      else $error("skipping request not refused");

   chk_op_green: assert property (
      (net_up && state_ff == FSL_ST_OP) |=> (net_ff.green && !net_ff.red))
      else $error("operational state not continuous green");

   chk_safeop_single: assert property (
      (net_up && state_ff == FSL_ST_SAFEOP) |=> (net_ff.green == $past(pat.single) && !net_ff.red))
      else $error("safe-operational not single green flash");

   chk_cfg_red_blink: assert property (
      (net_up && state_ff == FSL_ST_PREOP && i_cfg_invalid)
      |=> (net_ff.red == $past(pat.blink) && !net_ff.green))
      else $error("invalid configuration not red steady flash");

   chk_local_single: assert property (
      (i_comm_active && i_master_link && !wdg_any && i_local_fault)
      |=> (net_ff.red == $past(pat.single) && !net_ff.green))
      else $error("local fault not single red flash");

   chk_wdg_double: assert property (
      (i_comm_active && i_master_link && wdg_any) |=> (net_ff.red == $past(pat.dbl) && !net_ff.green))
      else $error("watchdog expiry not double red flash");

   chk_bus_error: assert property (
      (i_comm_active && !i_master_link) |=> (net_ff.red && !net_ff.green))
      else $error("bus error not continuous red");

   chk_pwr_error: assert property (
      i_dev_status.error |=> (pwr_ff.red && !pwr_ff.green))
      else $error("device error not continuous red");

   chk_pwr_service: assert property (
      (!i_dev_status.error && !i_dev_status.warning && i_dev_status.service_mode)
      |=> (pwr_ff.red && pwr_ff.green))
      else $error("service mode not orange");

   chk_pwr_init: assert property (
      (i_dev_status == 4'h0) |=> (pwr_ff.green == $past(pat.blink) && !pwr_ff.red))
      else $error("initialisation not green steady flash");

   chk_pwr_ready: assert property (
      (i_dev_status == 4'h8 && !seq_busy && !i_good_read && !i_no_read)
      |=> (pwr_ff.green && !pwr_ff.red))
      else $error("ready device not continuous green");

   // further state walk checks: accepted steps, refusals and their cause
   chk_accept_step: assert property (
      (i_comm_active && i_al_req.valid && i_al_req.target == fsl_slave_state_t'(state_ff + 2'h1)
       && !(state_ff == FSL_ST_PREOP && i_cfg_invalid))
      |=> (state_ff == $past(i_al_req.target) && !o_al_refused))
      else $error("legal step request not taken");

   chk_refuse_cause: assert property (
      o_al_refused |-> ($past(i_al_req.valid) && $past(i_comm_active)))
      else $error("refusal without a request");

   chk_cfg_refused: assert property (
      (i_comm_active && i_al_req.valid && state_ff == FSL_ST_PREOP && i_cfg_invalid
       && i_al_req.target == FSL_ST_SAFEOP)
      |=> (o_al_refused && state_ff == FSL_ST_PREOP))
      else $error("leaving pre-operational with bad configuration not refused");

   // further network checks: the states that the list above leaves out
   chk_init_dark: assert property (
      (net_up && state_ff == FSL_ST_INIT) |=> (!net_ff.green && !net_ff.red))
      else $error("network indicator lit in INIT");

   chk_preop_blink: assert property (
      (net_up && state_ff == FSL_ST_PREOP && !i_cfg_invalid)
      |=> (net_ff.green == $past(pat.blink) && !net_ff.red))
      else $error("pre-operational not green steady flash");

   // warning flash, which no check above covers
   chk_pwr_warning: assert property (
      (!i_dev_status.error && i_dev_status.warning)
      |=> (pwr_ff.red == $past(pat.blink) && !pwr_ff.green))
      else $error("warning not red flash");

   // main scenarios: read results, the state walk, the watchdog flash and a refusal
   cov_good_read: cover property (i_dev_status == 4'h8 && i_good_read ##2 !pwr_ff.green);
   cov_no_read_red: cover property (i_dev_status == 4'h8 && seq_color.red && pwr_ff.red);
   cov_reach_op: cover property (state_ff == FSL_ST_SAFEOP ##1 state_ff == FSL_ST_OP);
   cov_wdg_flash: cover property (i_comm_active && i_master_link && wdg_any ##1 net_ff.red);
   cov_cfg_refused: cover property (o_al_refused && state_ff == FSL_ST_PREOP && i_cfg_invalid);

endmodule : fsl_status_led
`default_nettype wire

// ===== test/fsl_master_model.sv
// fsl_master_model: behavioural fieldbus master that commands the slave state steps.
// assumes the slave state comes back from the encoder on the same core clock.
`timescale 1ns/10ps
`default_nettype none

module fsl_master_model
   import fsl_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_enable,
   input wire logic i_slow,
   input wire logic i_skip,
   input wire logic i_link_drop,
   input wire fsl_slave_state_t i_slave_state,
   input wire fsl_slave_state_t i_stop_at,
   output fsl_al_req_t o_al_req,
   output logic o_master_link
);
   logic [7:0] wait_ff;

   // link is up while the master runs; a scenario may cut it
   assign o_master_link = i_enable & ~i_link_drop;

   // one step per request; skip only when a scenario asks, from whatever state the slave is in
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_al_req <= '0;
         wait_ff <= 8'h00;
      end else begin
         o_al_req.valid <= 1'b0;
         // idle target keeps moving so a stale value is never trusted
         o_al_req.target <= fsl_slave_state_t'(~o_al_req.target);
         if (wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
         end else if (i_enable && i_slave_state < i_stop_at) begin
            o_al_req.valid <= 1'b1;
            o_al_req.target <= fsl_slave_state_t'(i_slave_state + (i_skip ? 2'h2 : 2'h1));
            wait_ff <= i_slow ? 8'h14 : 8'h03;
         end
      end
   end
endmodule : fsl_master_model
`default_nettype wire

// ===== test/fsl_status_led_tb.sv
// fsl_status_led_tb: self-checking bench for the status indicator encoder.
// assumes a shortened slot of 8 cycles, so one pattern frame is 64 cycles.
`timescale 1ns/10ps
`default_nettype none

module fsl_status_led_tb
   import fsl_pkg::*;
;
   localparam int unsigned TICKS = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   fsl_dev_status_t dev = 4'b1000;
   logic good = 1'b0;
   logic noread = 1'b0;
   logic comm = 1'b0;
   logic cfg_inv = 1'b0;
   logic lfault = 1'b0;
   fsl_wdg_t wdg = 3'b000;
   logic en = 1'b0;
   logic slow = 1'b0;
   logic skip = 1'b0;
   logic ldrop = 1'b0;
   fsl_slave_state_t stop = FSL_ST_INIT;
   fsl_al_req_t req;
   logic mlink;
   fsl_led_t power_status_indicator;
   fsl_led_t network_status_indicator;
   fsl_slave_state_t st;
   logic refused;
   logic [1:0] prev_st = 2'h0;
   int n_errors = 0;
   int samples_checked = 0;
   int n_refused = 0;

   fsl_status_led #(.TICK_CYCLES(TICKS)) i_fsl_status_led (.i_core_clk(clk), .i_arst_n(rst_n),
      .i_dev_status(dev), .i_good_read(good), .i_no_read(noread), .i_comm_active(comm),
      .i_master_link(mlink), .i_al_req(req), .i_cfg_invalid(cfg_inv), .i_local_fault(lfault),
      .i_wdg(wdg), .o_power_status_indicator(power_status_indicator), .o_network_status_indicator(network_status_indicator),
      .o_slave_state(st), .o_al_refused(refused));

   fsl_master_model i_fsl_master_model (.i_core_clk(clk), .i_arst_n(rst_n), .i_enable(en),
      .i_slow(slow), .i_skip(skip), .i_link_drop(ldrop), .i_slave_state(st), .i_stop_at(stop),
      .o_al_req(req), .o_master_link(mlink));

   // 20 MHz core clock
   initial begin
      forever #25 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input bit ok, input string msg);
      samples_checked++;
      if (!ok) begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk

   // counting lit cycles over one whole frame is phase independent
   task automatic count_led(input bit on_net, input int eg, input int er, input string msg);
      fsl_led_t v;
      int g = 0;
      int r = 0;
      repeat (4) @(negedge clk);
      repeat (64) begin
         @(negedge clk);
         v = on_net ? network_status_indicator : power_status_indicator;
         if (v.green === 1'b1) g++;
         if (v.red === 1'b1) r++;
      end
      chk(g == eg && r == er, msg);
   endtask : count_led

   task automatic wait_state(input fsl_slave_state_t s);
      int i = 0;
      while (st !== s && i < 100) begin
         @(negedge clk);
         i++;
      end
      chk(st === s, "slave state not reached");
   endtask : wait_state

   task automatic t_power();
      dev = 4'b0000;
      count_led(0, 32, 0, "init blink");
      dev = 4'b1000;
      count_led(0, 64, 0, "steady green");
      dev = 4'b1100;
      count_led(0, 64, 64, "service orange");
      dev = 4'b1110;
      count_led(0, 0, 32, "warning flash");
      dev = 4'b1111;
      count_led(0, 0, 64, "error red");
      dev = 4'b1000;
   endtask : t_power

   // nr also raises the good pulse: the failed read must win
   task automatic t_read(input bit nr);
      int d = 0;
      int r = 0;
      int i = 0;
      repeat (4) @(negedge clk);
      good = 1'b1;
      noread = nr;
      @(negedge clk);
      good = 1'b0;
      noread = 1'b0;
      repeat (2) @(negedge clk);
      while (power_status_indicator.green !== 1'b1 && i < 60) begin
         if (power_status_indicator === 2'b00) d++;
         if (power_status_indicator === 2'b01) r++;
         @(negedge clk);
         i++;
      end
      chk(d >= 7 && d <= 17 && r == (nr ? 16 : 0) && power_status_indicator === 2'b10, "read sequence");
   endtask : t_read

   task automatic t_walk();
      comm = 1'b0;
      count_led(1, 0, 0, "net dark inactive");
      comm = 1'b1;
      count_led(1, 0, 64, "bus error red");
      en = 1'b1;
      stop = FSL_ST_PREOP;
      wait_state(FSL_ST_PREOP);
      count_led(1, 32, 0, "preop blink");
      slow = 1'b1;
      stop = FSL_ST_SAFEOP;
      wait_state(FSL_ST_SAFEOP);
      count_led(1, 8, 0, "safeop single");
      stop = FSL_ST_OP;
      wait_state(FSL_ST_OP);
      count_led(1, 64, 0, "op green");
      slow = 1'b0;
   endtask : t_walk

   task automatic t_faults();
      lfault = 1'b1;
      count_led(1, 0, 8, "local fault single red");
      for (int k = 0; k < 3; k++) begin
         wdg = 3'b001 << k;
         count_led(1, 0, 16, "watchdog double red");
      end
      ldrop = 1'b1;
      count_led(1, 0, 64, "link lost red");
      en = 1'b0;
      comm = 1'b0;
      count_led(1, 0, 0, "comm off dark");
      chk(st === FSL_ST_INIT, "state not INIT");
      {lfault, wdg, ldrop} = 5'h00;
      stop = FSL_ST_OP;
   endtask : t_faults

   task automatic t_refuse();
      int r0 = n_refused;
      cfg_inv = 1'b1;
      comm = 1'b1;
      en = 1'b1;
      wait_state(FSL_ST_PREOP);
      count_led(1, 0, 32, "bad config red blink");
      chk(st === FSL_ST_PREOP && n_refused > r0, "safeop not refused");
      en = 1'b0;
      comm = 1'b0;
      cfg_inv = 1'b0;
      repeat (3) @(negedge clk);
      comm = 1'b1;
      skip = 1'b1;
      en = 1'b1;
      r0 = n_refused;
      repeat (12) @(negedge clk);
      chk(st === FSL_ST_INIT && n_refused > r0, "skip not refused");
      en = 1'b0;
      skip = 1'b0;
   endtask : t_refuse

   // count refusal pulses and watch that states never jump forward by more than one
   always @(negedge clk) begin
      if (refused === 1'b1) n_refused++;
      if (rst_n) begin
         chk(2'(st) <= prev_st || 2'(st) == 2'(prev_st + 2'h1), "state jumped");
         prev_st = 2'(st);
      end
   end

   // hang guard, about three and a half times the expected run of some 1250 cycles
   initial begin
      repeat (4500) @(posedge clk);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      repeat (4) @(posedge clk);
      chk(power_status_indicator === 2'b00 && network_status_indicator === 2'b00 && st === FSL_ST_INIT && refused === 1'b0, "reset");
      @(negedge clk);
      rst_n = 1'b1;
      t_power();
      t_read(1'b0);
      t_read(1'b1);
      t_walk();
      t_faults();
      t_refuse();
      report_and_stop();
   end
endmodule : fsl_status_led_tb
`default_nettype wire
